/* File: core/rfcs_defines.vh */
// Register map, field positions and reset values of the receive framer bank.
// Assumes inclusion by bare name from design files of this block.
`ifndef RFCS_DEFINES_VH
`define RFCS_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define RFCS_ADDR_W 12
`define RFCS_OFF_SPARE4 12'h0_069
`define RFCS_OFF_SPARE5 12'h0_06A
`define RFCS_OFF_SPARE6 12'h0_06B
`define RFCS_OFF_SPARE7 12'h0_06C
`define RFCS_OFF_SPARE8 12'h0_06D
`define RFCS_OFF_LAST 12'h0_06E
`define RFCS_OFF_CODE 12'h0_06F
`define RFCS_OFF_MASTER 12'h0_080
`define RFCS_OFF_CTRL1 12'h0_081
`define RFCS_OFF_MASK 12'h0_0F0
`define RFCS_OFF_STATUS 12'h0_0F1

// ****************************************
// Master mode fields
// ****************************************
`define RFCS_MM_ENABLE 7
`define RFCS_MM_INIT 6
`define RFCS_MM_SYNC_DIS 5
`define RFCS_MM_SOFT_RST 1
`define RFCS_MM_RATE 0
`define RFCS_MM_WMASK 8'hE3

// ****************************************
// Control 1 fields (RX_RATE_SELECT layouts)
// ****************************************
`define RFCS_C1_QUAL 7
`define RFCS_C1_LINE 6
`define RFCS_C1_FMT 5
`define RFCS_C1_CAUSE 4
`define RFCS_C1_SEARCH 3
`define RFCS_C1_CRC6J 2
`define RFCS_C1_ARDIS 1
`define RFCS_C1_RESYNC 0
`define RFCS_E1_SLOT26 4
`define RFCS_E1_CRIT 2
`define RFCS_E1_WMASK 8'h7F

// ****************************************
// Reset values and counts
// ****************************************
`define RFCS_RST_BYTE 8'h00
`define RFCS_QUAL_SHORT 5'd10
`define RFCS_QUAL_LONG 5'd24
`define RFCS_FAS_ERR_LIMIT 2'd3
`define RFCS_ODD_FRAMES 8

// Codeword classes
`define RFCS_CODE_8 4'h8
`define RFCS_CODE_A 4'hA
`define RFCS_CODE_C 4'hC
`define RFCS_CODE_E 4'hE
`define RFCS_CODE_F 4'hF

`endif

/* File: core/rfcs_regs.v */
// Receive framer control/status register bank for one port.
// Assumes a frame-timing source on the same clock that flags each odd
// (non-alignment) frame with its spare bits, frame index and multiframe end.
// Behaviour
// - Spare 4..8 bytes hold odd frames 15..1
// - Snapshot of last spare bits, low five
// - Watched spare change sets latched status bit0
// - Spare-6 codeword nibble, unaligned sampling
// - Classify codeword rotations into 8,A,C,E,F
// - Enable bit: low power off, active on
// - Init done starts operation if enabled
// - Bit 5 disables receive synchronizer
// - Soft reset level holds receiver, keeps registers
// - Bit 0 selects T1 or E1 receiver
// - T1 qualify length 10 or 24 bits
// - T1 zero-substitution decoding enable
// - T1 frame format ESF or D4
// - T1 resync cause OUT_OF_FRAME/LOSS_OF_SIGNAL or OUT_OF_FRAME
// - Sync search method per framing format
// - T1 standard or Japanese CRC-6
// - Auto resync enabled when bit1 low
// - Resync on rising edge of bit0
// - E1 layout of control register 1
// - E1 realign criteria, three errors
// - E1 signaling CAS or CCS
// - E1 HDB3 and CRC-4 enables
`include "rfcs_defines.vh"

module rfcs_regs #(
    parameter SPARE_N = 5
) (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Register port
    input wire [`RFCS_ADDR_W-1:0] addr,
    input wire [7:0] wr_data,
    input wire wr_strobe,
    input wire rd_strobe,
    output reg [7:0] rd_data,
    // Receive frame events
    input wire odd_frame_stb,
    input wire [2:0] odd_frame_idx,
    input wire multiframe_end,
    input wire [4:0] spare_bits_in,
    input wire out_of_frame,
    input wire loss_of_signal,
    input wire fas_error_stb,
    input wire nfas_bit2_error_stb,
    // Framer controls
    output reg framer_active,
    output reg framer_low_power,
    output reg rx_sync_disable,
    output reg rx_soft_reset,
    output reg rx_rate_select,
    output reg [4:0] sync_qualify_len,
    output reg rx_zero_subst_en,
    output reg rx_frame_format,
    output reg sync_search_method,
    output reg japan_crc6_select,
    output reg rx_e1_line_decode_en,
    output reg rx_signaling_type,
    output reg rx_slot26_block_en,
    output reg rx_multiframe_check_en,
    output reg resync_req,
    output reg spare_change_irq
);

    // ****************************************
    // Storage
    // ****************************************
    reg [7:0] master_mode;
    reg [7:0] ctrl1;
    reg [7:0] spare_change_mask;
    reg [7:0] latched_status_7;
    reg [7:0] spare_frames [0:SPARE_N-1];
    reg [7:0] spare_shadow [0:SPARE_N-1];
    reg [4:0] last_spare_bits;
    reg [3:0] spare6_hist;
    reg [3:0] spare6_code_bit;
    reg resync_prev;
    reg running;
    reg [1:0] fas_err_cnt;
    reg [7:0] next_rd_data;
    reg next_resync;

    wire is_e1 = master_mode[`RFCS_MM_RATE];
    wire sw_rst = master_mode[`RFCS_MM_SOFT_RST];
    wire wr_master = wr_strobe && (addr == `RFCS_OFF_MASTER);
    wire wr_ctrl1 = wr_strobe && (addr == `RFCS_OFF_CTRL1);
    wire wr_status = wr_strobe && (addr == `RFCS_OFF_STATUS);
    wire frame_ok = running && !sw_rst && is_e1;
    wire [4:0] spare_diff = (spare_bits_in ^ last_spare_bits) & spare_change_mask[4:0];
    wire spare_event = frame_ok && odd_frame_stb && (|spare_diff);

    // Rotation-insensitive codeword class
    function [3:0] classify;
        input [3:0] p;
        begin
            case (p)
                4'h8, 4'h4, 4'h2, 4'h1: begin
                    classify = `RFCS_CODE_8;
                end
                4'hA, 4'h5: begin
                    classify = `RFCS_CODE_A;
                end
                4'hC, 4'h6, 4'h3, 4'h9: begin
                    classify = `RFCS_CODE_C;
                end
                4'hE, 4'h7, 4'hB, 4'hD: begin
                    classify = `RFCS_CODE_E;
                end
                4'hF: begin
                    classify = `RFCS_CODE_F;
                end
                default: begin
                    classify = 4'h0;
                end
            endcase
        end
    endfunction

    // ****************************************
    // Master mode and control registers
    // ****************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            master_mode <= `RFCS_RST_BYTE;
            ctrl1 <= `RFCS_RST_BYTE;
            spare_change_mask <= `RFCS_RST_BYTE;
        end else begin
            if (wr_master) begin
                master_mode <= wr_data & `RFCS_MM_WMASK;
            end
            if (wr_ctrl1) begin
                ctrl1 <= is_e1 ? (wr_data & `RFCS_E1_WMASK) : wr_data;
            end
            if (wr_strobe && addr == `RFCS_OFF_MASK) begin
                spare_change_mask <= {3'b000, wr_data[4:0]};
            end
        end
    end

    // ****************************************
    // Run state
    // ****************************************
    // Init-done write examines enable; stops on the same edge as enable
    // drops, so active and low-power outputs never disagree
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            running <= 1'b0;
        end else if (wr_master) begin
            running <= wr_data[`RFCS_MM_INIT] && wr_data[`RFCS_MM_ENABLE];
        end
    end

    // ****************************************
    // Spare bit capture
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < SPARE_N; g = g + 1) begin : g_spare
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    spare_shadow[g] <= `RFCS_RST_BYTE;
                    spare_frames[g] <= `RFCS_RST_BYTE;
                end else if (frame_ok && odd_frame_stb) begin
                    // Frame 15 lands in bit 7, frame 1 in bit 0
                    spare_shadow[g][odd_frame_idx] <= spare_bits_in[SPARE_N-1-g];
                    if (multiframe_end) begin
                        spare_frames[g] <= spare_shadow[g];
                        spare_frames[g][odd_frame_idx] <= spare_bits_in[SPARE_N-1-g];
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Snapshot and codeword
    // ****************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            last_spare_bits <= 5'd0;
            spare6_hist <= 4'h0;
            spare6_code_bit <= 4'h0;
        end else if (frame_ok && odd_frame_stb) begin
            last_spare_bits <= spare_bits_in;
            // Free-running window, no submultiframe alignment
            spare6_hist <= {spare6_hist[2:0], spare_bits_in[2]};
            spare6_code_bit <= classify({spare6_hist[2:0], spare_bits_in[2]});
        end
    end

    // ****************************************
    // Change flag
    // ****************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latched_status_7 <= `RFCS_RST_BYTE;
        end else if (spare_event) begin
            // Set wins over a same-cycle clear
            latched_status_7[0] <= 1'b1;
        end else if (wr_status && wr_data[0]) begin
            latched_status_7[0] <= 1'b0;
        end
    end

    // ****************************************
    // E1 realignment criterion
    // ****************************************
    wire e1_err = fas_error_stb || (ctrl1[`RFCS_E1_CRIT] && nfas_bit2_error_stb);
    wire e1_loss = e1_err && (fas_err_cnt == `RFCS_FAS_ERR_LIMIT - 2'd1);
    wire t1_loss = out_of_frame || (!ctrl1[`RFCS_C1_CAUSE] && loss_of_signal);

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fas_err_cnt <= 2'd0;
        end else if (!frame_ok || e1_loss) begin
            fas_err_cnt <= 2'd0;
        end else if (e1_err) begin
            fas_err_cnt <= fas_err_cnt + 2'd1;
        end else if (odd_frame_stb) begin
            fas_err_cnt <= 2'd0;
        end
    end

    always @* begin
        next_resync = ctrl1[`RFCS_C1_RESYNC] && !resync_prev;
        if (!ctrl1[`RFCS_C1_ARDIS] && !master_mode[`RFCS_MM_SYNC_DIS]) begin
            next_resync = next_resync || (is_e1 ? e1_loss : t1_loss);
        end
        if (!running || sw_rst) begin
            next_resync = 1'b0;
        end
    end

    // ****************************************
    // Resync request
    // ****************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            resync_prev <= 1'b0;
            resync_req <= 1'b0;
        end else begin
            resync_prev <= ctrl1[`RFCS_C1_RESYNC];
            resync_req <= next_resync;
        end
    end

    // ****************************************
    // Master mode outputs
    // ****************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            framer_active <= 1'b0;
            framer_low_power <= 1'b1;
            rx_sync_disable <= 1'b0;
            rx_soft_reset <= 1'b0;
            rx_rate_select <= 1'b0;
        end else begin
            framer_active <= running;
            framer_low_power <= !master_mode[`RFCS_MM_ENABLE];
            rx_sync_disable <= master_mode[`RFCS_MM_SYNC_DIS];
            rx_soft_reset <= sw_rst;
            rx_rate_select <= is_e1;
        end
    end

    // ****************************************
    // T1 layout outputs
    // ****************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync_qualify_len <= `RFCS_QUAL_SHORT;
            rx_zero_subst_en <= 1'b0;
            rx_frame_format <= 1'b0;
            sync_search_method <= 1'b0;
            japan_crc6_select <= 1'b0;
        end else begin
            sync_qualify_len <= ctrl1[`RFCS_C1_QUAL] ?
                `RFCS_QUAL_LONG : `RFCS_QUAL_SHORT;
            rx_zero_subst_en <= !is_e1 && ctrl1[`RFCS_C1_LINE];
            rx_frame_format <= !is_e1 && ctrl1[`RFCS_C1_FMT];
            sync_search_method <= !is_e1 && ctrl1[`RFCS_C1_SEARCH];
            japan_crc6_select <= !is_e1 && ctrl1[`RFCS_C1_CRC6J];
        end
    end

    // ****************************************
    // E1 layout outputs
    // ****************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_e1_line_decode_en <= 1'b0;
            rx_signaling_type <= 1'b0;
            rx_slot26_block_en <= 1'b0;
            rx_multiframe_check_en <= 1'b0;
        end else begin
            rx_e1_line_decode_en <= is_e1 && ctrl1[`RFCS_C1_LINE];
            rx_signaling_type <= is_e1 && ctrl1[`RFCS_C1_FMT];
            rx_slot26_block_en <= is_e1 && ctrl1[`RFCS_E1_SLOT26];
            rx_multiframe_check_en <= is_e1 && ctrl1[`RFCS_C1_SEARCH];
        end
    end

    // ****************************************
    // Change interrupt
    // ****************************************
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            spare_change_irq <= 1'b0;
        end else begin
            spare_change_irq <= latched_status_7[0] || spare_event;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always @* begin
        case (addr)
            `RFCS_OFF_SPARE4: next_rd_data = spare_frames[0];
            `RFCS_OFF_SPARE5: next_rd_data = spare_frames[1];
            `RFCS_OFF_SPARE6: next_rd_data = spare_frames[2];
            `RFCS_OFF_SPARE7: next_rd_data = spare_frames[3];
            `RFCS_OFF_SPARE8: next_rd_data = spare_frames[4];
            `RFCS_OFF_LAST: next_rd_data = {3'b000, last_spare_bits};
            `RFCS_OFF_CODE: next_rd_data = {4'h0, spare6_code_bit};
            `RFCS_OFF_MASTER: next_rd_data = master_mode;
            `RFCS_OFF_CTRL1: next_rd_data = ctrl1;
            `RFCS_OFF_MASK: next_rd_data = spare_change_mask;
            `RFCS_OFF_STATUS: next_rd_data = latched_status_7;
            default: next_rd_data = 8'h00;
        endcase
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else if (rd_strobe) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= 8'h00;
        end
    end

endmodule // rfcs_regs

/* File: tb/rfcs_regs_assertions.sv */
// Port checker for the receive framer register bank.
// Assumes rfcs_regs ports; attached by the bind at the foot.
`include "rfcs_defines.vh"
module rfcs_regs_assertions #(
    parameter SPARE_N = 5
) (
    // Clock, reset and register port
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [11:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_data,
    // Framer controls
    input wire logic framer_active,
    input wire logic framer_low_power,
    input wire logic rx_sync_disable,
    input wire logic rx_soft_reset,
    input wire logic rx_rate_select,
    input wire logic [4:0] sync_qualify_len,
    input wire logic rx_zero_subst_en,
    input wire logic rx_frame_format,
    input wire logic sync_search_method,
    input wire logic japan_crc6_select,
    input wire logic rx_e1_line_decode_en,
    input wire logic rx_signaling_type,
    input wire logic rx_slot26_block_en,
    input wire logic rx_multiframe_check_en,
    input wire logic resync_req
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence mm_wr;
        wr_strobe && addr == `RFCS_OFF_MASTER;
    endsequence
    sequence c1_wr_t1;
        wr_strobe && addr == `RFCS_OFF_CTRL1 && !rx_rate_select;
    endsequence
    mode_write_a: assert property (mm_wr |-> ##2
        {rx_sync_disable, rx_soft_reset, rx_rate_select} ==
        {$past(wr_data[5], 2), $past(wr_data[1], 2), $past(wr_data[0], 2)})
        else $error("master mode outputs differ from written bits");
    mode_hold_a: assert property (!$past(wr_strobe) && !$past(wr_strobe, 2) |->
        $stable({rx_sync_disable, rx_soft_reset, rx_rate_select}))
        else $error("master mode outputs moved without a write");
    qual_len_a: assert property (c1_wr_t1 |-> ##2 sync_qualify_len ==
        ($past(wr_data[7], 2) ? `RFCS_QUAL_LONG : `RFCS_QUAL_SHORT))
        else $error("qualify length wrong");
    t1_fields_a: assert property (c1_wr_t1 |-> ##2
        {rx_zero_subst_en, rx_frame_format, sync_search_method, japan_crc6_select} ==
        {$past(wr_data[6], 2), $past(wr_data[5], 2), $past(wr_data[3], 2),
        $past(wr_data[2], 2)})
        else $error("t1 control outputs wrong");
    e1_quiet_a: assert property (!rx_rate_select |-> {rx_e1_line_decode_en,
        rx_signaling_type, rx_slot26_block_en, rx_multiframe_check_en} == 4'h0)
        else $error("e1 fields active in t1 mode");
    t1_quiet_a: assert property (rx_rate_select |-> {rx_zero_subst_en,
        rx_frame_format, sync_search_method, japan_crc6_select} == 4'h0)
        else $error("t1 fields active in e1 mode");
    power_state_a: assert property (framer_active |-> !framer_low_power)
        else $error("running while in low power");
    resync_pulse_a: assert property (resync_req |=> !resync_req)
        else $error("resync request longer than one cycle");
    snap_top_a: assert property (rd_strobe && addr == `RFCS_OFF_LAST |=>
        rd_data[7:5] == 3'b000)
        else $error("snapshot upper bits set");
    code_top_a: assert property (rd_strobe && addr == `RFCS_OFF_CODE |=>
        rd_data[7:4] == 4'h0)
        else $error("codeword upper bits set");
endmodule // rfcs_regs_assertions

bind rfcs_regs rfcs_regs_assertions #(.SPARE_N(SPARE_N)) rfcs_regs_assertions_i (
    .clock(clock), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .framer_active(framer_active), .framer_low_power(framer_low_power),
    .rx_sync_disable(rx_sync_disable), .rx_soft_reset(rx_soft_reset),
    .rx_rate_select(rx_rate_select), .sync_qualify_len(sync_qualify_len),
    .rx_zero_subst_en(rx_zero_subst_en), .rx_frame_format(rx_frame_format),
    .sync_search_method(sync_search_method), .japan_crc6_select(japan_crc6_select),
    .rx_e1_line_decode_en(rx_e1_line_decode_en), .rx_signaling_type(rx_signaling_type),
    .rx_slot26_block_en(rx_slot26_block_en),
    .rx_multiframe_check_en(rx_multiframe_check_en), .resync_req(resync_req));

/* File: tb/rfcs_regs_bench.sv */
// Self-checking bench for the receive framer register bank.
// Assumes rfcs_regs and its checker are compiled first.
`include "rfcs_defines.vh"
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end
module rfcs_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0, rst_b = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
    logic odd_frame_stb = 1'b0, multiframe_end = 1'b0;
    logic [11:0] addr = 12'h0_000;
    logic [7:0] wr_data = 8'h00, rd_data;
    logic [2:0] odd_frame_idx = 3'h0;
    logic [4:0] spare_bits_in = 5'h00, sync_qualify_len;
    logic framer_active, framer_low_power, rx_sync_disable, rx_soft_reset, rx_rate_select;
    logic rx_zero_subst_en, rx_frame_format, sync_search_method, japan_crc6_select;
    logic rx_e1_line_decode_en, rx_signaling_type, rx_slot26_block_en, rx_multiframe_check_en;
    logic resync_req, spare_change_irq;
    logic [7:0] exp_sp [5] = '{8'hAA, 8'hCC, 8'hF0, 8'hFF, 8'h00};
    logic [3:0] pat [4] = '{4'b1000, 4'b0101, 4'b0011, 4'b1011};
    logic [3:0] code [4] = '{4'h8, 4'hA, 4'hC, 4'hE};
    int n_fail = 0, cmp_count = 0;
    always #12.5 clock = ~clock;
    rfcs_regs rfcs_regs_i (.clock(clock), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .odd_frame_stb(odd_frame_stb), .odd_frame_idx(odd_frame_idx),
        .multiframe_end(multiframe_end), .spare_bits_in(spare_bits_in),
        .out_of_frame(1'b0), .loss_of_signal(1'b0), .fas_error_stb(1'b0),
        .nfas_bit2_error_stb(1'b0), .framer_active(framer_active),
        .framer_low_power(framer_low_power), .rx_sync_disable(rx_sync_disable),
        .rx_soft_reset(rx_soft_reset), .rx_rate_select(rx_rate_select),
        .sync_qualify_len(sync_qualify_len), .rx_zero_subst_en(rx_zero_subst_en),
        .rx_frame_format(rx_frame_format), .sync_search_method(sync_search_method),
        .japan_crc6_select(japan_crc6_select), .rx_e1_line_decode_en(rx_e1_line_decode_en),
        .rx_signaling_type(rx_signaling_type), .rx_slot26_block_en(rx_slot26_block_en),
        .rx_multiframe_check_en(rx_multiframe_check_en), .resync_req(resync_req),
        .spare_change_irq(spare_change_irq));
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick;
        @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input string what);
        @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1;
        `CHK(what, e, rd_data)
    endtask
    task automatic frame(input logic [2:0] i, input logic [4:0] b, input logic m);
        @(posedge clock);
        odd_frame_stb <= 1'b1;
        odd_frame_idx <= i;
        spare_bits_in <= b;
        multiframe_end <= m;
        @(posedge clock);
        odd_frame_stb <= 1'b0;
        multiframe_end <= 1'b0;
    endtask
    task automatic count_resync(input int exp_n);
        int n;
        n = 0;
        repeat (6) begin
            tick;
            if (resync_req === 1'b1) n++;
        end
        `CHK("resync pulses", exp_n, n)
    endtask
    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        #500000;
        n_fail++;
        stop_test;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        `CHK("low power", 1'b1, framer_low_power)
        `CHK("qualify", `RFCS_QUAL_SHORT, sync_qualify_len)
        for (int a = 'h69; a <= 'h6F; a++) rd(12'(a), 8'h00, "reset byte");
        rd(`RFCS_OFF_MASTER, 8'h00, "master reset");
        rd(`RFCS_OFF_CTRL1, 8'h00, "ctrl1 reset");
        rd(12'h0_070, 8'h00, "unmapped");
        wr(`RFCS_OFF_CTRL1, 8'hFE);
        tick;
        `CHK("t1 fields", 5'h1F, {rx_zero_subst_en, rx_frame_format, sync_search_method, japan_crc6_select, sync_qualify_len == `RFCS_QUAL_LONG})
        wr(`RFCS_OFF_MASTER, 8'h1D);
        rd(`RFCS_OFF_MASTER, 8'h01, "master mask");
        `CHK("e1 fields", 5'h0F, {rx_zero_subst_en, rx_e1_line_decode_en, rx_signaling_type, rx_slot26_block_en, rx_multiframe_check_en})
        wr(`RFCS_OFF_CTRL1, 8'hFE);
        rd(`RFCS_OFF_CTRL1, 8'h7E, "e1 ctrl1");
        `CHK("qualify e1", `RFCS_QUAL_SHORT, sync_qualify_len)
        wr(`RFCS_OFF_MASK, 8'h1F);
        wr(`RFCS_OFF_MASTER, 8'hC1);
        tick;
        `CHK("running", 2'b10, {framer_active, framer_low_power})
        for (int i = 0; i < 7; i++) frame(3'(i), {i[0], i[1], i[2], 2'b10}, 1'b0);
        rd(`RFCS_OFF_SPARE4, 8'h00, "before multiframe end");
        frame(3'h7, 5'b11110, 1'b1);
        for (int a = 0; a < 5; a++) rd(`RFCS_OFF_SPARE4 + 12'(a), exp_sp[a], "spare");
        rd(`RFCS_OFF_LAST, 8'h1E, "last spare bits");
        rd(`RFCS_OFF_CODE, 8'h0F, "codeword all ones");
        rd(`RFCS_OFF_STATUS, 8'h01, "change flag");
        `CHK("change irq", 1'b1, spare_change_irq)
        wr(`RFCS_OFF_STATUS, 8'h01);
        rd(`RFCS_OFF_STATUS, 8'h00, "change flag cleared");
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 4; j++) frame(3'(j), {2'b00, pat[k][j], 2'b00}, 1'b0);
            rd(`RFCS_OFF_CODE, {4'h0, code[k]}, "codeword");
        end
        wr(`RFCS_OFF_CTRL1, 8'h7F);
        count_resync(1);
        wr(`RFCS_OFF_CTRL1, 8'h7F);
        count_resync(0);
        wr(`RFCS_OFF_MASTER, 8'hC3);
        tick;
        `CHK("soft reset", 1'b1, rx_soft_reset)
        wr(`RFCS_OFF_CTRL1, 8'h7E);
        wr(`RFCS_OFF_CTRL1, 8'h7F);
        count_resync(0);
        rd(`RFCS_OFF_CTRL1, 8'h7F, "kept under soft reset");
        wr(`RFCS_OFF_MASTER, 8'hE1);
        rd(`RFCS_OFF_MASTER, 8'hE1, "sync disable");
        `CHK("sync disable out", 1'b1, rx_sync_disable)
        wr(`RFCS_OFF_MASTER, 8'h00);
        tick;
        `CHK("stopped", 3'b010, {framer_active, framer_low_power, rx_rate_select})
        stop_test;
    end
endmodule // rfcs_regs_bench
